// ### core/canmb_core.sv
`timescale 1ns/1ps
// Functional notes
// - Thirteen-byte buffers, contents undefined after reset
// - Receive buffer read-only; transmit buffers read/write
// - Extended identifier packed across four bytes
// - Standard identifier packed in bytes zero, one
// - 11 or 29 bit identifier, MSB first
// - Smallest identifier value has highest priority
// - SRR written as one, stored as received
// - Format flag selects standard or extended
// - Remote flag: zero data, one remote
// - Four-bit length code, counts 0 to 8
// - Remote frame sends length, no data
// - Only length-code bytes sent or stored
// - Transmit buffers carry 8-bit local priority
// - Arbitrate pending buffers right before SOF
// - Equal priority: lowest buffer index wins
// - Sleep request sleeps once bus idle
// - Soft reset aborts, holds control registers
// - Config registers writable only in soft reset
// - Resync: 11 recessive, bus-off 128 times
module canmb_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  output logic tx_pending,
  input wire logic tx_start,
  output canmb_pkg::canmb_frame_t tx_frame,
  output logic [3:0] tx_byte_count,
  output logic [1:0] tx_buf_index,
  input wire logic tx_done,
  input wire logic rx_busy,
  input wire logic rx_store,
  input wire canmb_pkg::canmb_frame_t rx_frame,
  input wire logic bit_tick,
  input wire logic bus_bit,
  input wire logic bus_off,
  output logic frame_abort,
  output logic bus_synced,
  output logic sleeping,
  output canmb_pkg::canmb_cfg_t timing_cfg
);
  logic [7:0] frame_mem [canmb_pkg::NUM_BUF][canmb_pkg::FRAME_BYTES];
  logic [7:0] prio [canmb_pkg::NUM_TX];
  logic [7:0] module_control_0, module_control_1, bit_timing_0, bit_timing_1;
  logic [7:0] receive_irq_enable, transmit_control, acceptance_control;
  logic [7:0] acceptance_code [4];
  logic [7:0] acceptance_mask [4];
  logic [2:0] tx_empty;
  logic rx_full;
  logic soft_reset, sleep_request;
  logic [1:0] arb_idx;
  logic [1:0] wr_buf;
  logic [3:0] wr_byte, rx_count;
  logic buf_hit, wr_tx_buf, wr_reg;
  logic [3:0] sync_count;
  logic [7:0] seq_count;
  logic [7:0] next_rdata;

  assign soft_reset = module_control_0[canmb_pkg::CTL0_SOFT];
  assign sleep_request = module_control_0[canmb_pkg::CTL0_SLEEP];
  assign buf_hit = cpu_addr[canmb_pkg::BUF_SEL_BIT];
  assign wr_buf = cpu_addr[5:4];
  assign wr_byte = cpu_addr[3:0];
  assign wr_reg = cpu_wr && !buf_hit;
  // Writes to the receive slot fall through this decode and are dropped.
  assign wr_tx_buf = cpu_wr && buf_hit && (wr_buf != 2'h0);
  assign frame_abort = soft_reset;
  assign timing_cfg = '{bit_timing_1, bit_timing_0, module_control_1};

  function automatic logic [3:0] canmb_count(input logic [3:0] code, input logic remote);
    logic [3:0] n;
    n = (code > canmb_pkg::LEN_MAX) ? canmb_pkg::LEN_MAX : code;
    return remote ? 4'h0 : n;
  endfunction

  // Strict compare keeps the lower index on a tie.
  always_comb begin
    arb_idx = 2'h0;
    tx_pending = 1'b0;
    for (int i = 0; i < canmb_pkg::NUM_TX; i++) begin
      if (!tx_empty[i] && (!tx_pending || prio[i] < prio[arb_idx - 2'h1])) begin
        arb_idx = 2'(i + 1);
        tx_pending = 1'b1;
      end
    end
    if (soft_reset || sleeping) begin
      tx_pending = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      module_control_0 <= canmb_pkg::CTL0_RESET;
    end else if (wr_reg && cpu_addr == canmb_pkg::OFS_CTL0) begin
      if (soft_reset) begin
        module_control_0 <= canmb_pkg::CTL0_RESET & {7'h00, cpu_wdata[canmb_pkg::CTL0_SOFT]};
      end else begin
        module_control_0 <= cpu_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      receive_irq_enable <= canmb_pkg::REG_RESET;
      transmit_control <= canmb_pkg::REG_RESET;
    end else if (soft_reset) begin
      receive_irq_enable <= canmb_pkg::REG_RESET;
      transmit_control <= canmb_pkg::REG_RESET;
    end else if (wr_reg) begin
      if (cpu_addr == canmb_pkg::OFS_RXIEN) begin
        receive_irq_enable <= cpu_wdata;
      end
      if (cpu_addr == canmb_pkg::OFS_TXCTL) begin
        transmit_control <= cpu_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      module_control_1 <= canmb_pkg::REG_RESET;
      bit_timing_0 <= canmb_pkg::REG_RESET;
      bit_timing_1 <= canmb_pkg::REG_RESET;
      acceptance_control <= canmb_pkg::REG_RESET;
      for (int i = 0; i < 4; i++) begin
        acceptance_code[i] <= canmb_pkg::REG_RESET;
        acceptance_mask[i] <= canmb_pkg::REG_RESET;
      end
    end else if (wr_reg && soft_reset) begin
      case (cpu_addr)
        canmb_pkg::OFS_CTL1: module_control_1 <= cpu_wdata;
        canmb_pkg::OFS_BT0: bit_timing_0 <= cpu_wdata;
        canmb_pkg::OFS_BT1: bit_timing_1 <= cpu_wdata;
        canmb_pkg::OFS_ACC_CTL: acceptance_control <= cpu_wdata;
        default: begin
          if (cpu_addr[6:2] == canmb_pkg::OFS_ACC_CODE[6:2]) begin
            acceptance_code[cpu_addr[1:0]] <= cpu_wdata;
          end
          if (cpu_addr[6:2] == canmb_pkg::OFS_ACC_MASK[6:2]) begin
            acceptance_mask[cpu_addr[1:0]] <= cpu_wdata;
          end
        end
      endcase
    end
  end

  // Empty flags: software clears by writing one; a finished send sets, and wins.
  always_ff @(posedge clk) begin
    if (!rst_b || soft_reset) begin
      tx_empty <= canmb_pkg::TXFLG_RESET;
    end else begin
      for (int i = 0; i < canmb_pkg::NUM_TX; i++) begin
        if (tx_done && tx_buf_index == 2'(i + 1)) begin
          tx_empty[i] <= 1'b1;
        end else if (wr_reg && cpu_addr == canmb_pkg::OFS_TXFLG && cpu_wdata[i]) begin
          tx_empty[i] <= 1'b0;
        end
      end
    end
  end

  // Full flag: set by a stored frame, cleared by writing one; set wins.
  always_ff @(posedge clk) begin
    if (!rst_b || soft_reset) begin
      rx_full <= 1'b0;
    end else if (rx_store) begin
      rx_full <= 1'b1;
    end else if (wr_reg && cpu_addr == canmb_pkg::OFS_RXFLG && cpu_wdata[canmb_pkg::RXFLG_FULL]) begin
      rx_full <= 1'b0;
    end
  end

  assign rx_count = canmb_count(rx_frame.length_code, rx_frame.remote);

  // Buffer contents carry no reset value.
  always_ff @(posedge clk) begin
    if (rx_store && !rx_full && !soft_reset) begin
      if (rx_frame.ext) begin
        frame_mem[0][0] <= rx_frame.ident[28:21];
        frame_mem[0][1] <= {rx_frame.ident[20:18], rx_frame.srr, 1'b1, rx_frame.ident[17:15]};
        frame_mem[0][2] <= rx_frame.ident[14:7];
        frame_mem[0][3] <= {rx_frame.ident[6:0], rx_frame.remote};
      end else begin
        frame_mem[0][0] <= rx_frame.ident[10:3];
        frame_mem[0][1] <= {rx_frame.ident[2:0], rx_frame.remote, 1'b0, 3'h0};
      end
      frame_mem[0][canmb_pkg::OFS_LEN] <= {4'h0, rx_frame.length_code};
      for (int b = 0; b < 8; b++) begin
        if (4'(b) < rx_count) begin
          frame_mem[0][b + 4] <= rx_frame.data[63 - 8 * b -: 8];
        end
      end
    end
    if (wr_tx_buf && wr_byte <= canmb_pkg::OFS_LEN) begin
      frame_mem[wr_buf][wr_byte] <= cpu_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_tx_buf && wr_byte == canmb_pkg::OFS_PRIO) begin
      prio[wr_buf - 2'h1] <= cpu_wdata;
    end
  end

  // Selected buffer is latched at the start-of-frame request.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_buf_index <= 2'h0;
      tx_frame <= '0;
      tx_byte_count <= 4'h0;
    end else if (tx_start && tx_pending) begin
      tx_buf_index <= arb_idx;
      tx_frame.ext <= frame_mem[arb_idx][1][canmb_pkg::ID1_EXT];
      tx_frame.srr <= frame_mem[arb_idx][1][canmb_pkg::ID1_SRR];
      tx_frame.length_code <= frame_mem[arb_idx][canmb_pkg::OFS_LEN][3:0];
      for (int b = 0; b < 8; b++) begin
        tx_frame.data[63 - 8 * b -: 8] <= frame_mem[arb_idx][b + 4];
      end
      if (frame_mem[arb_idx][1][canmb_pkg::ID1_EXT]) begin
        tx_frame.ident <= {frame_mem[arb_idx][0], frame_mem[arb_idx][1][7:5], frame_mem[arb_idx][1][2:0],
                           frame_mem[arb_idx][2], frame_mem[arb_idx][3][7:1]};
        tx_frame.remote <= frame_mem[arb_idx][3][canmb_pkg::ID3_RTR];
        tx_byte_count <= canmb_count(frame_mem[arb_idx][canmb_pkg::OFS_LEN][3:0],
                                     frame_mem[arb_idx][3][canmb_pkg::ID3_RTR]);
      end else begin
        tx_frame.ident <= {18'h0, frame_mem[arb_idx][0], frame_mem[arb_idx][1][7:5]};
        tx_frame.remote <= frame_mem[arb_idx][1][canmb_pkg::ID1_STD_RTR];
        tx_byte_count <= canmb_count(frame_mem[arb_idx][canmb_pkg::OFS_LEN][3:0],
                                     frame_mem[arb_idx][1][canmb_pkg::ID1_STD_RTR]);
      end
    end else if (tx_done || soft_reset) begin
      tx_buf_index <= 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || soft_reset) begin
      sleeping <= 1'b0;
    end else if (!sleep_request) begin
      sleeping <= 1'b0;
    end else if (!rx_busy && tx_empty == canmb_pkg::TXFLG_RESET && tx_buf_index == 2'h0) begin
      sleeping <= 1'b1;
    end
  end

  // Eleven recessive bits end each idle sequence; bus-off needs 128 of them.
  always_ff @(posedge clk) begin
    if (!rst_b || soft_reset) begin
      sync_count <= 4'h0;
      seq_count <= 8'h00;
      bus_synced <= 1'b0;
    end else if (bit_tick && !bus_synced) begin
      if (!bus_bit) begin
        sync_count <= 4'h0;
      end else if (sync_count == canmb_pkg::SYNC_BITS - 4'h1) begin
        sync_count <= 4'h0;
        if (!bus_off) begin
          bus_synced <= 1'b1;
        end else if (seq_count == canmb_pkg::BUSOFF_SEQ - 8'h01) begin
          bus_synced <= 1'b1;
        end else begin
          seq_count <= seq_count + 8'h01;
        end
      end else begin
        sync_count <= sync_count + 4'h1;
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (buf_hit) begin
      if (wr_byte <= canmb_pkg::OFS_LEN) begin
        next_rdata = frame_mem[wr_buf][wr_byte];
      end else if (wr_byte == canmb_pkg::OFS_PRIO && wr_buf != 2'h0) begin
        next_rdata = prio[wr_buf - 2'h1];
      end
    end else begin
      case (cpu_addr)
        canmb_pkg::OFS_CTL0: next_rdata = module_control_0;
        canmb_pkg::OFS_CTL1: next_rdata = module_control_1;
        canmb_pkg::OFS_BT0: next_rdata = bit_timing_0;
        canmb_pkg::OFS_BT1: next_rdata = bit_timing_1;
        canmb_pkg::OFS_RXFLG: next_rdata = {7'h00, rx_full};
        canmb_pkg::OFS_RXIEN: next_rdata = receive_irq_enable;
        canmb_pkg::OFS_TXFLG: next_rdata = {5'h00, tx_empty};
        canmb_pkg::OFS_TXCTL: next_rdata = transmit_control;
        canmb_pkg::OFS_ACC_CTL: next_rdata = acceptance_control;
        default: begin
          if (cpu_addr[6:2] == canmb_pkg::OFS_ACC_CODE[6:2]) begin
            next_rdata = acceptance_code[cpu_addr[1:0]];
          end else if (cpu_addr[6:2] == canmb_pkg::OFS_ACC_MASK[6:2]) begin
            next_rdata = acceptance_mask[cpu_addr[1:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence start_taken_s;
    tx_start && tx_pending;
  endsequence

  sequence stored_s;
    rx_store && !soft_reset;
  endsequence

  soft_hold_a: assert property (soft_reset |=> tx_empty == 3'h7 && !rx_full && !bus_synced)
    else $error("Soft reset did not hold flags.");
  timing_lock_a: assert property (wr_reg && cpu_addr == 7'h02 && !soft_reset |=> $stable(bit_timing_0))
    else $error("Timing register written outside soft reset.");
  remote_nodata_a: assert property (start_taken_s ##1 tx_frame.remote |-> tx_byte_count == 4'h0)
    else $error("Remote frame carries data bytes.");
  count_clip_a: assert property (start_taken_s |=> tx_byte_count <= 4'h8)
    else $error("Byte count exceeds eight.");
  arb_lowest_a: assert property (start_taken_s |=> tx_buf_index != 2'h0
    && (tx_empty[0] || prio[tx_buf_index - 2'h1] <= prio[0])
    && (tx_empty[1] || prio[tx_buf_index - 2'h1] <= prio[1])
    && (tx_empty[2] || prio[tx_buf_index - 2'h1] <= prio[2]))
    else $error("Arbitration winner not lowest priority.");
  tie_index_a: assert property (start_taken_s ##1 (!tx_empty[0] && tx_buf_index > 2'h1) |->
    prio[0] > prio[tx_buf_index - 2'h1])
    else $error("Tie not resolved to lowest index.");
  done_frees_a: assert property (tx_done && tx_buf_index != 2'h0 && !soft_reset |=>
    tx_empty[$past(tx_buf_index) - 2'h1])
    else $error("Finished buffer not marked empty.");
  rx_full_a: assert property (stored_s |=> rx_full [*1] ##1 1'b1)
    else $error("Stored frame did not set full flag.");
  sleep_gate_a: assert property (sleeping |-> $past(sleep_request) && !tx_pending)
    else $error("Sleep without request or with pending send.");
  sleep_idle_a: assert property ($rose(sleeping) |-> $past(tx_empty) == 3'h7 && !$past(rx_busy))
    else $error("Sleep entered while bus not idle.");
  ext_format_a: assert property (stored_s and (!rx_full && rx_frame.ext) |=>
    frame_mem[0][1][3] && frame_mem[0][1][4] == $past(rx_frame.srr))
    else $error("Extended flag or SRR stored wrongly.");
endmodule

// ### core/canmb_pkg.sv
package canmb_pkg;
  localparam int NUM_TX = 3;
  localparam int NUM_BUF = 4;
  localparam int FRAME_BYTES = 13;
  // Register offsets inside the 128-byte module window.
  localparam logic [6:0] OFS_CTL0 = 7'h00;
  localparam logic [6:0] OFS_CTL1 = 7'h01;
  localparam logic [6:0] OFS_BT0 = 7'h02;
  localparam logic [6:0] OFS_BT1 = 7'h03;
  localparam logic [6:0] OFS_RXFLG = 7'h04;
  localparam logic [6:0] OFS_RXIEN = 7'h05;
  localparam logic [6:0] OFS_TXFLG = 7'h06;
  localparam logic [6:0] OFS_TXCTL = 7'h07;
  localparam logic [6:0] OFS_ACC_CTL = 7'h08;
  localparam logic [6:0] OFS_ACC_CODE = 7'h10;
  localparam logic [6:0] OFS_ACC_MASK = 7'h14;
  localparam logic [3:0] OFS_LEN = 4'hC;
  localparam logic [3:0] OFS_PRIO = 4'hD;
  localparam int BUF_SEL_BIT = 6;
  // Field positions.
  localparam int CTL0_SOFT = 0;
  localparam int CTL0_SLEEP = 1;
  localparam int RXFLG_FULL = 0;
  localparam int ID1_SRR = 4;
  localparam int ID1_EXT = 3;
  localparam int ID1_STD_RTR = 4;
  localparam int ID3_RTR = 0;
  // Reset values.
  localparam logic [7:0] CTL0_RESET = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] TXFLG_RESET = 3'h7;
  // Frame and synchronisation constants.
  localparam logic [3:0] LEN_MAX = 4'h8;
  localparam logic [3:0] SYNC_BITS = 4'hB;
  localparam logic [7:0] BUSOFF_SEQ = 8'h80;

  typedef struct packed {
    logic [28:0] ident;
    logic ext;
    logic remote;
    logic srr;
    logic [3:0] length_code;
    logic [63:0] data;
  } canmb_frame_t;

  typedef struct packed {
    logic [7:0] bit_timing_1;
    logic [7:0] bit_timing_0;
    logic [7:0] module_control_1;
  } canmb_cfg_t;
endpackage

// ### sim/can_message_buffer_control_tb_top.sv
`timescale 1ns/1ps
module can_message_buffer_control_tb_top;
  logic clk;
  logic rst_b = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [6:0] cpu_addr = 7'h00;
  logic [7:0] cpu_wdata = 8'h00;
  logic rx_busy = 1'b0;
  logic rx_store = 1'b0;
  logic bit_tick = 1'b0;
  logic bus_bit = 1'b1;
  logic bus_off = 1'b0;
  logic en = 1'b1;
  logic [7:0] hold = 8'h01;
  canmb_pkg::canmb_frame_t rx_frame = '0;
  canmb_pkg::canmb_frame_t tx_frame;
  canmb_pkg::canmb_cfg_t timing_cfg;
  logic [7:0] cpu_rdata;
  logic [3:0] tx_byte_count;
  logic [1:0] tx_buf_index;
  logic tx_pending, tx_start, tx_done, frame_abort, bus_synced, sleeping;
  int fail_count, n_tests, cyc;
  int mb [64];
  logic [31:0] r = 32'h580813EB;

  canmb_core dut (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .tx_pending(tx_pending),
    .tx_start(tx_start), .tx_frame(tx_frame), .tx_byte_count(tx_byte_count),
    .tx_buf_index(tx_buf_index), .tx_done(tx_done), .rx_busy(rx_busy), .rx_store(rx_store),
    .rx_frame(rx_frame), .bit_tick(bit_tick), .bus_bit(bus_bit), .bus_off(bus_off),
    .frame_abort(frame_abort), .bus_synced(bus_synced), .sleeping(sleeping),
    .timing_cfg(timing_cfg));
  canmb_engine_model eng (.clk(clk), .rst_b(rst_b), .enable(en), .hold(hold),
    .tx_pending(tx_pending), .frame_abort(frame_abort), .tx_start(tx_start), .tx_done(tx_done));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    @(negedge clk);
    chk(n, e & m, cpu_rdata & m);
  endtask

  task automatic tick(input logic b);
    @(posedge clk);
    bit_tick <= 1'b1;
    bus_bit <= b;
    @(posedge clk);
    bit_tick <= 1'b0;
  endtask

  task automatic store(input canmb_pkg::canmb_frame_t fr);
    @(posedge clk);
    rx_frame <= fr;
    rx_store <= 1'b1;
    @(posedge clk);
    rx_store <= 1'b0;
  endtask

  task automatic wait_for(input logic busy);
    int i;
    for (i = 0; i < 300 && ((tx_buf_index != 2'h0) != busy); i++) begin
      @(negedge clk);
    end
    chk("handshake wait", 1, i < 300);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    int n, w, b0;
    logic x, rm;
    logic [28:0] eid;
    logic [63:0] dat;
    logic [7:0] v;
    logic [7:0] eb [4];
    canmb_pkg::canmb_frame_t f;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rchk(7'h00, 8'h01, 8'hFF, "control0");
    rchk(7'h06, 8'h07, 8'hFF, "tx flags");
    rchk(7'h04, 8'h00, 8'h01, "rx full");
    rchk(7'h0A, 8'h00, 8'hFF, "unmapped");
    $display("test reset done");
    wr(7'h02, 8'hA5);
    wr(7'h03, 8'h5A);
    wr(7'h00, 8'h00);
    wr(7'h02, 8'h3C);
    rchk(7'h02, 8'hA5, 8'hFF, "timing0");
    chk("timing cfg", 24'h5AA500, timing_cfg);
    $display("test config done");
    repeat (10) tick(1'b1);
    tick(1'b0);
    repeat (10) tick(1'b1);
    repeat (2) @(negedge clk);
    chk("synced early", 0, bus_synced);
    tick(1'b1);
    repeat (2) @(negedge clk);
    chk("synced", 1, bus_synced);
    $display("test sync done");
    for (int e = 0; e < 2; e++) begin
      r = lfsr(r);
      f.ident = (e == 1) ? r[28:0] : {18'h0, r[10:0]};
      f.ext = e[0];
      f.remote = r[29];
      f.srr = r[30];
      r = lfsr(r);
      f.length_code = r[3:0];
      f.data = {r, ~r};
      store(f);
      n = f.remote ? 0 : (f.length_code > 8 ? 8 : int'(f.length_code));
      eb[0] = f.ext ? f.ident[28:21] : f.ident[10:3];
      eb[1] = f.ext ? {f.ident[20:18], f.srr, 1'b1, f.ident[17:15]} : {f.ident[2:0], f.remote, 4'h0};
      eb[2] = f.ident[14:7];
      eb[3] = {f.ident[6:0], f.remote};
      for (int k = 0; k < (f.ext ? 4 : 2); k++) begin
        rchk(7'(64 + k), eb[k], (f.ext || k == 0) ? 8'hFF : 8'hF8, "rx id");
      end
      rchk(7'h4C, {4'h0, f.length_code}, 8'h0F, "rx length");
      for (int k = 0; k < n; k++) begin
        rchk(7'(68 + k), f.data[63 - 8 * k -: 8], 8'hFF, "rx data");
      end
      rchk(7'h04, 8'h01, 8'h01, "rx full");
      store(~f);
      rchk(7'h40, eb[0], 8'hFF, "rx kept");
      wr(7'h40, ~eb[0]);
      rchk(7'h40, eb[0], 8'hFF, "rx read only");
      wr(7'h04, 8'h01);
      rchk(7'h04, 8'h00, 8'h01, "rx released");
    end
    $display("test receive done");
    for (int rnd = 0; rnd < 2; rnd++) begin
      hold <= rnd ? 8'h28 : 8'h01;
      for (int k = 0; k < 42; k++) begin
        r = lfsr(r);
        v = r[7:0];
        v[4] = (k % 14 == 1) ? v[4] | v[3] : v[4];
        v = (k % 14 == 13 && rnd == 1) ? 8'h00 : v;
        mb[k + 2 * (k / 14)] = int'(v);
        wr(7'(80 + k + 2 * (k / 14)), v);
      end
      wr(7'h06, 8'h07);
      for (int t = 0, p = 7; t < 3; t++) begin
        w = 3;
        for (int b = 0; b < 3; b++) begin
          if (p[b] && (w == 3 || mb[16 * b + 13] < mb[16 * w + 13])) begin
            w = b;
          end
        end
        b0 = 16 * w;
        x = mb[b0 + 1][3];
        rm = x ? mb[b0 + 3][0] : mb[b0 + 1][4];
        eid = x ? {mb[b0][7:0], mb[b0 + 1][7:5], mb[b0 + 1][2:0], mb[b0 + 2][7:0], mb[b0 + 3][7:1]}
              : {18'h0, mb[b0][7:0], mb[b0 + 1][7:5]};
        n = rm ? 0 : (mb[b0 + 12][3:0] > 8 ? 8 : int'(mb[b0 + 12][3:0]));
        for (int k = 0; k < 8; k++) begin
          dat = {dat[55:0], mb[b0 + 4 + k][7:0]};
        end
        wait_for(1'b1);
        chk("tx index", w + 1, tx_buf_index);
        chk("tx ident", eid, tx_frame.ident);
        chk("tx format", x, tx_frame.ext);
        if (x) chk("tx srr", 1, tx_frame.srr);
        chk("tx remote", rm, tx_frame.remote);
        chk("tx length", mb[b0 + 12][3:0], tx_frame.length_code);
        chk("tx count", n, tx_byte_count);
        chk("tx data", dat & ~(~64'h0 >> (8 * n)), tx_frame.data & ~(~64'h0 >> (8 * n)));
        wait_for(1'b0);
        p[w] = 0;
      end
      rchk(7'h06, 8'h07, 8'hFF, "tx flags");
    end
    $display("test transmit done");
    @(posedge clk);
    rx_busy <= 1'b1;
    wr(7'h00, 8'h02);
    repeat (3) @(negedge clk);
    chk("sleep while busy", 0, sleeping);
    @(posedge clk);
    rx_busy <= 1'b0;
    repeat (3) @(negedge clk);
    chk("sleep", 1, sleeping);
    wr(7'h00, 8'h00);
    repeat (2) @(negedge clk);
    chk("awake", 0, sleeping);
    $display("test sleep done");
    hold <= 8'hC8;
    wr(7'h06, 8'h01);
    wait_for(1'b1);
    en <= 1'b0;
    rchk(7'h06, 8'h06, 8'hFF, "tx pending");
    wr(7'h00, 8'h01);
    rchk(7'h06, 8'h07, 8'hFF, "tx flags soft");
    chk("abort", 1, frame_abort);
    chk("sync lost", 0, bus_synced);
    chk("tx aborted", 0, tx_buf_index);
    $display("test soft reset done");
    @(posedge clk);
    bus_off <= 1'b1;
    wr(7'h00, 8'h00);
    repeat (1397) tick(1'b1);
    repeat (2) @(negedge clk);
    chk("bus-off early", 0, bus_synced);
    repeat (11) tick(1'b1);
    repeat (2) @(negedge clk);
    chk("bus-off synced", 1, bus_synced);
    $display("test bus-off sync done");
    give_verdict();
  end
endmodule

// ### sim/canmb_engine_model.sv
`timescale 1ns/1ps
// Stand-in for the protocol engine. It sends whenever enabled and a buffer is pending,
// reports the frame sent hold + 1 cycles after the start, then keeps an inter-frame gap.
module canmb_engine_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [7:0] hold,
  input wire logic tx_pending,
  input wire logic frame_abort,
  output logic tx_start,
  output logic tx_done
);
  int cnt;
  logic busy;
  always_ff @(posedge clk) begin
    tx_start <= 1'b0;
    tx_done <= 1'b0;
    if (!rst_b || frame_abort) begin
      busy <= 1'b0;
      cnt <= 0;
    end else if (!busy) begin
      if (enable && tx_pending) begin
        tx_start <= 1'b1;
        busy <= 1'b1;
        cnt <= 0;
      end
    end else begin
      cnt <= cnt + 1;
      if (cnt == int'(hold)) begin
        tx_done <= 1'b1;
      end
      if (cnt == int'(hold) + 3) begin
        busy <= 1'b0;
      end
    end
  end
endmodule
